// [logic/snc_regs.sv]
// register bank and low-dimension router of one switch node
`timescale 1ns/1ps
`include "snc_defs.svh"

module snc_regs
  import snc_pkg::*;
#(
  parameter int RELOCK_CYC = `SNC_RELOCK_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration requests
  input wire logic req_valid,
  input wire snc_req_type req,
  output snc_rsp_type rsp,
  output logic rsp_valid,
  // pins and one-time-programmable values
  input wire logic [7:0] boot_control_pins,
  input wire logic [31:0] tp_device_id,
  input wire logic [13:0] otp_user_code,
  input wire logic [17:0] metal_id,
  input wire logic mul_locked,
  // clock multiplier and clock control
  output snc_clk_type clk_ctl,
  output logic tile_reset,
  output logic [15:0] sw_div,
  output logic [15:0] ref_div,
  output logic one_byte_header,
  // routing of the low identifier bits
  input wire logic route_valid,
  input wire logic [15:0] route_dest,
  output logic route_done,
  output logic route_local,
  output logic [3:0] route_dir
);

  // ****************************************
  // reset and input synchronisers
  // ****************************************
  logic [1:0] rst_pipe;
  logic rst_s_n;
  logic [56:0] pin_meta;
  logic [56:0] pin_sync;
  logic [56:0] pin_raw;

  // async assert, clocked release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end

  assign rst_s_n = rst_pipe[1];
  assign pin_raw = {boot_control_pins, tp_device_id, otp_user_code,
                    mul_locked, metal_id[1:0]};

  // pins come from outside the clock domain
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      pin_meta <= 57'h0;
      pin_sync <= 57'h0;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // metal id bits above 1 are static straps; synced separately
  logic [15:0] metal_meta;
  logic [15:0] metal_sync;

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      metal_meta <= 16'h0000;
      metal_sync <= 16'h0000;
    end
    else
    begin
      metal_meta <= metal_id[17:2];
      metal_sync <= metal_meta;
    end
  end

  wire [7:0] boot_sync = pin_sync[56:49];
  wire [31:0] tp_id_sync = pin_sync[48:17];
  wire [13:0] user_sync = pin_sync[16:3];
  wire locked_sync = pin_sync[2];
  wire [17:0] metal_all = {metal_sync, pin_sync[1:0]};

  // ****************************************
  // boot pin capture after power-on reset
  // ****************************************
  // wait until the synchroniser holds real pin levels
  logic [1:0] boot_wait;
  logic boot_taken;
  logic [7:0] boot_latch;

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      boot_wait <= 2'h0;
      boot_taken <= 1'b0;
      boot_latch <= 8'h00;
    end
    else if (!boot_taken)
    begin
      boot_wait <= boot_wait + 2'h1;
      if (boot_wait == 2'h3)
      begin
        boot_taken <= 1'b1;
        boot_latch <= boot_sync;
      end
    end
  end

  // ****************************************
  // request decode
  // ****************************************
  logic [31:0] cfg;
  logic [15:0] node_id;
  logic [31:0] mul;
  logic [31:0] dir_lo;

  wire ctl_lock = cfg[`SNC_CFG_CTL_LOCK];
  wire mul_lock = cfg[`SNC_CFG_MUL_LOCK];
  wire wr = req_valid && req.write;
  wire rd = req_valid && !req.write;
  wire hit_ident = req.number == `SNC_REG_IDENT;
  wire hit_descr = req.number == `SNC_REG_DESCR;
  wire hit_cfg = req.number == `SNC_REG_CONFIG;
  wire hit_node = req.number == `SNC_REG_NODE_ID;
  wire hit_mul = req.number == `SNC_REG_CLKMUL;
  wire hit_swd = req.number == `SNC_REG_SW_DIV;
  wire hit_refd = req.number == `SNC_REG_REF_DIV;
  wire hit_tp = req.number == `SNC_REG_TP_ID;
  wire hit_user = req.number == `SNC_REG_USER;
  wire hit_dir = req.number == `SNC_REG_DIR_LO;
  wire hit_rw = hit_cfg | hit_node | hit_mul | hit_swd | hit_refd
                | hit_dir;
  wire hit_any = hit_rw | hit_ident | hit_descr | hit_tp | hit_user;

  // the control lock guards every writable register, itself included,
  // so once set it holds until reset
  wire wr_ok = wr && !ctl_lock;
  wire wr_cfg = wr_ok && hit_cfg;
  wire wr_node = wr_ok && hit_node;
  wire wr_mul = wr_ok && hit_mul && !mul_lock;
  wire wr_swd = wr_ok && hit_swd;
  wire wr_refd = wr_ok && hit_refd;
  wire wr_dir = wr_ok && hit_dir;
  wire wr_refused = wr && hit_rw && !(wr_cfg | wr_node | wr_mul
                    | wr_swd | wr_refd | wr_dir);

  // ****************************************
  // writable registers
  // ****************************************
  // only documented bits stored; reserved bits stay zero
  wire [31:0] cfg_mask = 32'h8000_0101;
  logic [15:0] sw_div_q;
  logic [15:0] ref_div_q;

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      cfg <= 32'h0000_0000;
      node_id <= 16'h0000;
      mul <= `SNC_MUL_RESET;
      sw_div_q <= `SNC_SW_DIV_RESET;
      ref_div_q <= `SNC_REF_DIV_RESET;
      dir_lo <= `SNC_DIR_RESET;
    end
    else
    begin
      if (wr_cfg)
        cfg <= req.wdata & cfg_mask;
      if (wr_node)
        node_id <= req.wdata[15:0];
      if (wr_mul)
        mul <= req.wdata & `SNC_MUL_WMASK;
      if (wr_swd)
        sw_div_q <= req.wdata[15:0];
      if (wr_refd)
        ref_div_q <= req.wdata[15:0];
      if (wr_dir)
        dir_lo <= req.wdata;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  wire [31:0] rd_ident = {8'h00, boot_latch, `SNC_REVISION,
                          `SNC_VERSION};
  wire [31:0] rd_descr = {8'h00, `SNC_LINK_COUNT, `SNC_SW_CORES,
                          `SNC_DEV_CORES};
  wire [31:0] rd_user = {user_sync, metal_all};
  wire [31:0] rd_data =
    hit_ident ? rd_ident :
    hit_descr ? rd_descr :
    hit_cfg ? cfg :
    hit_node ? {16'h0000, node_id} :
    hit_mul ? mul :
    hit_swd ? {16'h0000, sw_div_q} :
    hit_refd ? {16'h0000, ref_div_q} :
    hit_tp ? tp_id_sync :
    hit_user ? rd_user :
    hit_dir ? dir_lo : 32'h0000_0000;

  // one answer per request, the cycle after it is taken
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      rsp_valid <= 1'b0;
      rsp <= '0;
    end
    else
    begin
      rsp_valid <= req_valid;
      rsp.ack <= req_valid && hit_any && !wr_refused;
      rsp.error <= req_valid && (!hit_any || wr_refused);
      rsp.rdata <= (rd && hit_any) ? rd_data : 32'h0000_0000;
    end
  end

  // ****************************************
  // clock multiplier outputs
  // ****************************************
  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
      clk_ctl <= '0;
    else
    begin
      clk_ctl.bypass <= mul[`SNC_MUL_BYPASS];
      clk_ctl.tp_boot <= mul[`SNC_MUL_TP_BOOT];
      clk_ctl.out_ratio <= {1'b0, mul[25:23]} + 4'h1;
      clk_ctl.fb_ratio <= {1'b0, mul[20:8]} + 14'h0001;
      clk_ctl.in_ratio <= {1'b0, mul[6:0]} + 8'h01;
    end
  end

  assign sw_div = sw_div_q;
  assign ref_div = ref_div_q;
  assign one_byte_header = cfg[`SNC_CFG_HDR_ONE];

  // ****************************************
  // tile reset sequencer
  // ****************************************
  // waits for relock (or a timeout) before the one-cycle tile reset pulse; a write with SNC_MUL_NO_RELOCK set skips the wait
  snc_state_type state;
  snc_state_type next_state;
  logic [31:0] wait_cnt;
  wire no_reset = req.wdata[`SNC_MUL_NO_RESET];
  wire no_relock = req.wdata[`SNC_MUL_NO_RELOCK];
  wire wait_over = locked_sync || (wait_cnt >= RELOCK_CYC - 1);

  always_comb
  begin
    next_state = state;
    case (state)
      SNC_IDLE:
      begin
        if (wr_mul && !no_reset)
          next_state = no_relock ? SNC_RST : SNC_WAIT;
      end
      SNC_WAIT:
      begin
        if (wr_mul && no_reset)
          next_state = SNC_IDLE;
        else if (wait_over)
          next_state = SNC_RST;
      end
      SNC_RST:
        next_state = SNC_IDLE;
      default:
        next_state = SNC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      state <= SNC_IDLE;
      wait_cnt <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      wait_cnt <= (state == SNC_WAIT) ? wait_cnt + 32'h0000_0001
                                      : 32'h0000_0000;
    end
  end

  assign tile_reset = state == SNC_RST;

  // ****************************************
  // low-dimension routing
  // ****************************************
  // only bits 7..0 are compared; upper bits belong to another table
  logic [7:0] diff;
  logic [2:0] msb;
  logic any_diff;

  always_comb
  begin
    diff = route_dest[7:0] ^ node_id[7:0];
    msb = 3'h0;
    any_diff = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      if (diff[k])
      begin
        msb = 3'(k);
        any_diff = 1'b1;
      end
    end
  end

  wire [3:0] dir_pick = dir_lo[{msb, 2'b00} +: 4];

  always_ff @(posedge clk or negedge rst_s_n)
  begin
    if (!rst_s_n)
    begin
      route_done <= 1'b0;
      route_local <= 1'b0;
      route_dir <= 4'h0;
    end
    else
    begin
      route_done <= route_valid;
      route_local <= route_valid && !any_diff;
      route_dir <= (route_valid && any_diff) ? dir_pick : 4'h0;
    end
  end

endmodule : snc_regs

// [pkg/snc_defs.svh]
// constants of the switch node configuration register bank
`ifndef SNC_DEFS_SVH
`define SNC_DEFS_SVH

// ****************************************
// register numbers
// ****************************************
`define SNC_REG_IDENT 8'h00
`define SNC_REG_DESCR 8'h01
`define SNC_REG_CONFIG 8'h04
`define SNC_REG_NODE_ID 8'h05
`define SNC_REG_CLKMUL 8'h06
`define SNC_REG_SW_DIV 8'h07
`define SNC_REG_REF_DIV 8'h08
`define SNC_REG_TP_ID 8'h09
`define SNC_REG_USER 8'h0a
`define SNC_REG_DIR_LO 8'h0c

// ****************************************
// field positions and reset values
// ****************************************
`define SNC_CFG_CTL_LOCK 31
`define SNC_CFG_MUL_LOCK 8
`define SNC_CFG_HDR_ONE 0
`define SNC_MUL_NO_RESET 31
`define SNC_MUL_NO_RELOCK 30
`define SNC_MUL_BYPASS 29
`define SNC_MUL_TP_BOOT 28
`define SNC_MUL_WMASK 32'hf39f_ff7f
`define SNC_MUL_RESET 32'h0000_0000
`define SNC_SW_DIV_RESET 16'h0000
`define SNC_REF_DIV_RESET 16'h0003
`define SNC_DIR_RESET 32'h0000_0000

// identity values are arbitrary
`define SNC_REVISION 8'h01
`define SNC_VERSION 8'h02
`define SNC_LINK_COUNT 8'h04
`define SNC_SW_CORES 8'h02
`define SNC_DEV_CORES 8'h02

// relock wait, 100 us at 40 MHz
`define SNC_RELOCK_US 100
`define SNC_CLK_MHZ 40
`define SNC_RELOCK_CYC (`SNC_RELOCK_US * `SNC_CLK_MHZ)

`endif

// [pkg/snc_pkg.sv]
// types of the switch node configuration register bank
package snc_pkg;

  // configuration request from the switch network
  typedef struct packed {
    logic write;
    logic [7:0] number;
    logic [31:0] wdata;
  } snc_req_type;

  // answer to a request
  typedef struct packed {
    logic ack;
    logic error;
    logic [31:0] rdata;
  } snc_rsp_type;

  // clock multiplier outputs
  typedef struct packed {
    logic bypass;
    logic tp_boot;
    logic [3:0] out_ratio;
    logic [13:0] fb_ratio;
    logic [7:0] in_ratio;
  } snc_clk_type;

  typedef enum logic [2:0] {
    SNC_IDLE = 3'b001,
    SNC_WAIT = 3'b010,
    SNC_RST = 3'b100
  } snc_state_type;

endpackage : snc_pkg

// [sim/snc_regs_assertions.sv]
// assertion checker for the switch node register bank
`timescale 1ns/1ps
module snc_regs_checker
  import snc_pkg::*;
#(
  parameter int RELOCK_CYC = 8
)
(
  // clock and reset
  input logic clk,
  input logic rst_n,
  // requests and answers
  input logic req_valid,
  input snc_req_type req,
  input snc_rsp_type rsp,
  input logic rsp_valid,
  // clock controls
  input snc_clk_type clk_ctl,
  input logic tile_reset,
  input logic [15:0] sw_div,
  input logic one_byte_header,
  // routing
  input logic route_valid,
  input logic route_done,
  input logic route_local,
  input logic [3:0] route_dir
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // write strobes per register number
  wire wr_cfg = req_valid && req.write && req.number == 8'h04;
  wire wr_mul = req_valid && req.write && req.number == 8'h06;
  wire wr_sw = req_valid && req.write && req.number == 8'h07;

  // ******************************
  // properties
  // ******************************
  a_answer_next: assert property (req_valid |=> rsp_valid)
    else $error("no answer after a request");
  a_answer_cause: assert property (rsp_valid |-> $past(req_valid))
    else $error("answer without a request");
  a_header_write: assert property ($changed(one_byte_header) |->
    $past(wr_cfg) && one_byte_header == $past(req.wdata[0]))
    else $error("header mode changed without a write");
  a_swdiv_write: assert property ($changed(sw_div) |->
    $past(wr_sw) && sw_div == $past(req.wdata[15:0]))
    else $error("switch divider changed without a write");
  a_mul_flags: assert property (wr_mul && req.wdata[31:30] == 2'b01
    ##1 (rsp_valid && rsp.ack) |-> tile_reset ##1
    (clk_ctl.bypass == $past(req.wdata[29], 2)
    && clk_ctl.tp_boot == $past(req.wdata[28], 2)))
    else $error("multiplier write flags or tile reset wrong");
  a_mul_ratios: assert property (wr_mul ##1 (rsp_valid && rsp.ack) |=>
    clk_ctl.in_ratio == 8'($past(req.wdata[6:0], 2)) + 8'h01
    && clk_ctl.fb_ratio == 14'($past(req.wdata[20:8], 2)) + 14'h0001
    && clk_ctl.out_ratio == 4'($past(req.wdata[25:23], 2)) + 4'h1)
    else $error("multiplier ratios not field plus one");
  a_skip_reset: assert property (wr_mul && req.wdata[31] |=>
    !tile_reset [*4])
    else $error("tile reset despite suppression");
  a_pulse_once: assert property (tile_reset |=> !tile_reset)
    else $error("tile reset longer than one cycle");
  a_route_next: assert property (route_valid |=> route_done)
    else $error("no route answer");
  a_route_quiet: assert property (!route_done |->
    !route_local && route_dir == 4'h0)
    else $error("route outputs set outside answer");
endmodule : snc_regs_checker

bind snc_regs snc_regs_checker #(.RELOCK_CYC(RELOCK_CYC)) snc_regs_checker_i (
  .clk, .rst_n, .req_valid, .req, .rsp, .rsp_valid, .clk_ctl,
  .tile_reset, .sw_div, .one_byte_header, .route_valid, .route_done,
  .route_local, .route_dir);

// [sim/snc_requester.sv]
// configuration requester model on the switch network side
`timescale 1ns/1ps
module snc_requester
  import snc_pkg::*;
(
  // clock
  input logic clk,
  // request side
  output logic req_valid,
  output snc_req_type req,
  // answer side
  input snc_rsp_type rsp,
  input logic rsp_valid
);
  // idle until the first request
  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end

  // one request by register number, answer awaited a few cycles
  task automatic op(input logic wr, input logic [7:0] num,
    input logic [31:0] wd, output snc_rsp_type r, output logic got);
    int n;
    got = 1'b0;
    r = '0;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{wr, num, wd};
    @(negedge clk);
    req_valid = 1'b0;
    // released lines must not keep the last word
    req = '{~wr, ~num, ~wd};
    for (n = 0; n < 4 && !got; n++)
    begin
      if (rsp_valid === 1'b1)
      begin
        got = 1'b1;
        r = rsp;
      end
      else
        @(negedge clk);
    end
  endtask : op
endmodule : snc_requester

// [sim/snc_regs_tb_top.sv]
// self-checking bench of the switch node register bank
`timescale 1ns/1ps
`include "snc_defs.svh"
module snc_regs_tb_top
  import snc_pkg::*;
;
  // request beside the answer it should give
  typedef struct packed {
    logic wr;
    logic [7:0] num;
    logic [31:0] wd;
    logic err;
    logic [31:0] rd;
  } snc_row_type;

  localparam logic [7:0] PINS = 8'ha5;
  localparam logic [31:0] TP_ID = 32'h1234_5678;
  localparam logic [31:0] USER = {14'h1abc, 18'h2_5a5a};
  logic clk = 0, rst_n = 0, mul_locked = 0, route_valid = 0;
  logic [15:0] route_dest = '0, sw_div, ref_div;
  logic req_valid, rsp_valid, tile_reset, one_byte_header;
  logic route_done, route_local;
  logic [3:0] route_dir;
  snc_req_type req;
  snc_rsp_type rsp, r;
  snc_clk_type clk_ctl;
  int fail_count = 0, checks = 0, n;
  snc_row_type rows [20] = '{
    '{0, 8'h00, 0, 0, {8'h00, PINS, `SNC_REVISION, `SNC_VERSION}},
    '{0, 8'h01, 0, 0, {8'h00, `SNC_LINK_COUNT, `SNC_SW_CORES,
      `SNC_DEV_CORES}},
    '{0, 8'h04, 0, 0, 0}, '{0, 8'h05, 0, 0, 0}, '{0, 8'h07, 0, 0, 0},
    '{0, 8'h08, 0, 0, 3}, '{0, 8'h09, 0, 0, TP_ID},
    '{0, 8'h0a, 0, 0, USER}, '{0, 8'h0c, 0, 0, 0}, '{0, 8'h02, 0, 1, 0},
    '{1, 8'h01, 32'hffff_ffff, 0, 0}, '{0, 8'h0b, 0, 1, 0},
    '{1, 8'h05, 32'hffff_1234, 0, 0}, '{0, 8'h05, 0, 0, 32'h1234},
    '{1, 8'h07, 32'hffff_abcd, 0, 0}, '{0, 8'h07, 0, 0, 32'habcd},
    '{1, 8'h0c, 32'h7654_3210, 0, 0}, '{0, 8'h0c, 0, 0, 32'h7654_3210},
    '{1, 8'h08, 32'hffff_0042, 0, 0}, '{0, 8'h08, 0, 0, 32'h0000_0042}};

  always #12.5 clk = ~clk;

  snc_regs #(.RELOCK_CYC(8)) snc_regs_i (.clk, .rst_n, .req_valid, .req,
    .rsp, .rsp_valid, .boot_control_pins(PINS), .tp_device_id(TP_ID),
    .otp_user_code(USER[31:18]), .metal_id(USER[17:0]), .mul_locked,
    .clk_ctl, .tile_reset, .sw_div, .ref_div, .one_byte_header,
    .route_valid, .route_dest, .route_done, .route_local, .route_dir);
  snc_requester snc_requester_i (.clk, .req_valid, .req, .rsp, .rsp_valid);

  // ******************************
  // shared tasks
  // ******************************
  task automatic check(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // a lost answer ends the run, nothing after it means much
  task automatic xfer(input logic wr, input logic [7:0] num,
    input logic [31:0] wd);
    logic got;
    snc_requester_i.op(wr, num, wd, r, got);
    if (got !== 1'b1)
    begin
      fail_count++;
      $display("MISMATCH answer expected 1 seen 0");
      tally_and_finish();
    end
  endtask : xfer

  // cycles until the tile reset pulse, bounded by lim
  task automatic pulse_gap(input int lim);
    for (n = 0; n < lim && tile_reset !== 1'b1; n++)
      @(negedge clk);
  endtask : pulse_gap

  // main sequence, inputs change at the falling edge
  initial
  begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    check("ref_div", 3, ref_div);
    check("sw_div", 0, sw_div);
    check("header", 0, one_byte_header);
    check("clk_ctl", {6'h0, 4'h1, 14'h1, 8'h1}, clk_ctl);
    $display("reset test done");
    foreach (rows[i])
    begin
      xfer(rows[i].wr, rows[i].num, rows[i].wd);
      check("flags", {~rows[i].err, rows[i].err}, {r.ack, r.error});
      if (!rows[i].wr)
        check("rdata", rows[i].rd, r.rdata);
    end
    $display("table test done");
    xfer(1, 8'h06, 32'h7fff_ff85);
    pulse_gap(6);
    check("tile_reset", 1, tile_reset);
    repeat (2) @(negedge clk);
    check("clk_ctl", {2'b11, 4'h8, 14'h2000, 8'h6}, clk_ctl);
    xfer(0, 8'h06, 0);
    check("mul read", 32'h739f_ff05, r.rdata);
    xfer(1, 8'h06, 32'h8000_0000);
    pulse_gap(12);
    check("no reset", 12, n);
    xfer(1, 8'h06, 0);
    pulse_gap(30);
    check("relock wait", 1, n >= 6 && n < 30);
    // a locked multiplier ends the wait as soon as the lock is synced
    mul_locked = 1'b1;
    repeat (4) @(negedge clk);
    xfer(1, 8'h06, 0);
    pulse_gap(30);
    check("lock wait", 1, n);
    mul_locked = 1'b0;
    $display("multiplier test done");
    for (int k = -1; k < 8; k++)
    begin
      route_valid = 1'b1;
      route_dest = {8'hff, 8'h34 ^ (k < 0 ? 8'h00 : (8'h01 << k) | 8'h01)};
      @(negedge clk);
      route_valid = 1'b0;
      check("route", k < 0 ? 32'h30 : 32'h20 | k,
        {route_done, route_local, route_dir});
      @(negedge clk);
    end
    $display("routing test done");
    xfer(1, 8'h04, 32'h0000_0001);
    check("header", 1, one_byte_header);
    xfer(1, 8'h04, 32'h0000_0100);
    xfer(1, 8'h06, 0);
    check("mul lock", 2'b01, {r.ack, r.error});
    xfer(1, 8'h04, 32'h8000_0000);
    xfer(1, 8'h05, 32'h5555);
    check("ctl lock", 2'b01, {r.ack, r.error});
    xfer(0, 8'h05, 0);
    check("node id", 32'h1234, r.rdata);
    $display("lock test done");
    // second reset mid-run must clear the sticky control lock
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    check("ref_div", 3, ref_div);
    check("sw_div", 0, sw_div);
    xfer(0, 8'h05, 0);
    check("node id", 0, r.rdata);
    xfer(1, 8'h05, 32'h0000_00ab);
    check("lock cleared", 2'b10, {r.ack, r.error});
    $display("second reset test done");
    tally_and_finish();
  end
endmodule : snc_regs_tb_top
